/* core/gicr_pin_ovr.v */
// Purpose: One software override of a multiplexed pin
// Assumes: Control code from a register field
// Notes: Output registered
`include "gicr_defines.vh"
module gicr_pin_ovr #(
  parameter INT_MODE = 1
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire [1:0] i_ctl,
  input wire i_internal,
  input wire i_allow,
  output reg o_out,
  output reg o_oe
);
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_out <= 1'b0;
      o_oe <= 1'b0;
    end else if (i_ce) begin
      o_out <= i_ctl[0];
      o_oe <= i_allow & i_ctl[1];
      if (INT_MODE != 0 && i_ctl == `GICR_PIN_INTERNAL) begin
        o_out <= i_internal;
        o_oe <= i_allow;
      end
    end
  end
endmodule

/* core/gicr_regs.v */
// Purpose: Init configuration registers four, five and six
// Assumes: Decoded single-phase register access; strap inputs stable at reset release
// Notes: Writes act at once, outside the input FIFO path
`include "gicr_defines.vh"
// Notes on behaviour
// - Writes dropped unless write unlock bit set
// - Writes take effect immediately, bypassing FIFO
// - Bit zero selects one or two wait states
// - Bit one enables frame buffer read ahead
// - Spill when free space below low mark
// - Memory FIFO start row and rollover row
// - Stop disable bit loads strap at reset release
// - Strap copies read only except bits zero, three and four, caught at release
// - Two-bit field picks buffer memory layout
// - Drivers for slave clock and bit sixteen
// - Video clock select from bit thirteen and an input
// - Retrace reads synchronised when bit fifteen
// - Border edge enables and scan doubling
// - Full 24-bit or double-pumped DAC output
// - Sync inversion, gamma and interlace bits
// - General pin one source and drive gating
// - Active and drag counters for swap 1,2
// - Interleave master bit only for swap 3
// - General pin two, three, sync-in overrides
// - Sync-out, read, write strobe overrides
// - FIFO ready low from empty entries mark
module gicr_regs #(
  parameter FIFO_CNT_W = 7
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_config_write_unlock,
  input wire i_wr,
  input wire [1:0] i_sel,
  input wire [31:0] i_wdata,
  output reg [31:0] o_rdata,
  input wire [8:0] i_frame_mem_addr_b_straps,
  input wire i_sli_syncin_strap,
  input wire [1:0] i_swap_alg,
  input wire i_init_config_one_vsel,
  input wire [FIFO_CNT_W-1:0] i_pci_fifo_free,
  input wire i_gpio2_in,
  input wire i_gpio3_in,
  input wire i_sli_syncin_in,
  input wire i_sli_syncout_in,
  input wire i_dac_rd_in,
  input wire i_dac_wr_in,
  input wire i_sli_syncout_int,
  input wire i_dac_rd_int,
  input wire i_dac_wr_int,
  output reg o_read_two_ws,
  output reg o_read_ahead_en,
  output reg o_mem_fifo_spill,
  output reg [9:0] o_mem_fifo_start_row,
  output reg [9:0] o_mem_fifo_rollover_row,
  output reg o_stop_disable,
  output reg [1:0] o_buffer_alloc,
  output reg o_vid_clk_slave_oe,
  output reg o_dac_d16_oe,
  output reg [1:0] o_vclk_sel,
  output reg o_retrace_sync,
  output reg [3:0] o_border_en,
  output reg [1:0] o_scan_double,
  output reg o_gamma_en,
  output reg o_hsync_invert,
  output reg o_vsync_invert,
  output reg o_full24,
  output reg o_interlace,
  output reg o_gpio1_out,
  output reg o_gpio1_oe,
  output reg [2:0] o_active_cnt,
  output reg [4:0] o_drag_cnt,
  output reg o_sli_master,
  output reg o_fifo_rdy_n,
  output wire o_gpio2_out,
  output wire o_gpio2_oe,
  output wire o_gpio3_out,
  output wire o_gpio3_oe,
  output wire o_sli_syncin_out,
  output wire o_sli_syncin_oe,
  output wire o_sli_syncout_out,
  output wire o_sli_syncout_oe,
  output wire o_dac_rd_out,
  output wire o_dac_rd_oe,
  output wire o_dac_wr_out,
  output wire o_dac_wr_oe
);
  // ********************************
  // Storage and strap capture
  // ********************************
  reg [31:0] four_q;
  reg [31:0] five_q;
  reg [31:0] six_q;
  reg strap_done_q;
  wire wr_ok = i_ce & i_wr & i_config_write_unlock;
  wire [31:0] strap_bits = {17'h00000, i_sli_syncin_strap, 5'h00, i_frame_mem_addr_b_straps};

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_done_q <= 1'b0;
    end else if (i_ce) begin
      strap_done_q <= 1'b1;
    end
  end

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      four_q <= `GICR_FOUR_RESET;
      five_q <= 32'h00000000;
      six_q <= 32'h00000000;
    end else if (i_ce) begin
      if (!strap_done_q) begin
        five_q <= strap_bits & (`GICR_F5_RO_MASK | 32'h00000019);
      end else if (wr_ok) begin
        case (i_sel)
          `GICR_SEL_FOUR: four_q <= i_wdata & `GICR_FOUR_MASK;
          `GICR_SEL_FIVE: five_q <= (five_q & `GICR_F5_RO_MASK) | (i_wdata & `GICR_FIVE_WMASK);
          `GICR_SEL_SIX: six_q <= i_wdata & `GICR_SIX_WMASK;
          default: four_q <= four_q;
        endcase
      end
    end
  end

  // ********************************
  // Pin overrides
  // ********************************
  wire allow16 = ~five_q[`GICR_F5_W24];
  gicr_pin_ovr #(
    .INT_MODE(0)
  ) u_gp2 (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_ctl(six_q[10:9]),
    .i_internal(1'b0),
    .i_allow(allow16),
    .o_out(o_gpio2_out),
    .o_oe(o_gpio2_oe)
  );

  gicr_pin_ovr #(
    .INT_MODE(0)
  ) u_gp3 (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_ctl(six_q[12:11]),
    .i_internal(1'b0),
    .i_allow(allow16),
    .o_out(o_gpio3_out),
    .o_oe(o_gpio3_oe)
  );

  gicr_pin_ovr #(
    .INT_MODE(0)
  ) u_sin (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_ctl(six_q[14:13]),
    .i_internal(1'b0),
    .i_allow(1'b1),
    .o_out(o_sli_syncin_out),
    .o_oe(o_sli_syncin_oe)
  );

  gicr_pin_ovr #(
    .INT_MODE(1)
  ) u_sout (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_ctl(six_q[16:15]),
    .i_internal(i_sli_syncout_int),
    .i_allow(1'b1),
    .o_out(o_sli_syncout_out),
    .o_oe(o_sli_syncout_oe)
  );

  gicr_pin_ovr #(
    .INT_MODE(1)
  ) u_rd (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_ctl(six_q[18:17]),
    .i_internal(i_dac_rd_int),
    .i_allow(1'b1),
    .o_out(o_dac_rd_out),
    .o_oe(o_dac_rd_oe)
  );

  gicr_pin_ovr #(
    .INT_MODE(1)
  ) u_wr (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_ctl(six_q[20:19]),
    .i_internal(i_dac_wr_int),
    .i_allow(1'b1),
    .o_out(o_dac_wr_out),
    .o_oe(o_dac_wr_oe)
  );

  // ********************************
  // Read back
  // ********************************
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (i_sel)
      `GICR_SEL_FOUR: rd_d = four_q;
      `GICR_SEL_FIVE: rd_d = five_q;
      `GICR_SEL_SIX: begin
        rd_d = six_q;
        rd_d[10:9] = {2{i_gpio2_in}};
        rd_d[12:11] = {2{i_gpio3_in}};
        rd_d[14:13] = {2{i_sli_syncin_in}};
        rd_d[16:15] = {2{i_sli_syncout_in}};
        rd_d[18:17] = {2{i_dac_rd_in}};
        rd_d[20:19] = {2{i_dac_wr_in}};
      end
      default: rd_d = 32'h00000000;
    endcase
  end

  // ********************************
  // Decoded controls
  // ********************************
  wire [6:0] mark6 = {1'b0, four_q[7:2]};
  wire [7:0] free8 = {{(8-FIFO_CNT_W){1'b0}}, i_pci_fifo_free};
  wire swap12 = (i_swap_alg == 2'h1) | (i_swap_alg == 2'h2);
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
      o_read_two_ws <= 1'b1;
      o_read_ahead_en <= 1'b0;
      o_mem_fifo_spill <= 1'b0;
      o_mem_fifo_start_row <= 10'h000;
      o_mem_fifo_rollover_row <= 10'h000;
    end else if (i_ce) begin
      o_rdata <= rd_d;
      o_read_two_ws <= four_q[`GICR_F4_WS];
      o_read_ahead_en <= four_q[`GICR_F4_RA];
      o_mem_fifo_spill <= ({1'b0, free8[6:0]} < {1'b0, mark6});
      o_mem_fifo_start_row <= four_q[17:8];
      o_mem_fifo_rollover_row <= four_q[27:18];
    end
  end

  // ********************************
  // Register five controls
  // ********************************
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_stop_disable <= 1'b0;
      o_buffer_alloc <= 2'h0;
      o_vid_clk_slave_oe <= 1'b0;
      o_dac_d16_oe <= 1'b0;
      o_vclk_sel <= 2'h0;
      o_retrace_sync <= 1'b0;
      o_border_en <= 4'h0;
      o_scan_double <= 2'h0;
      o_gamma_en <= 1'b0;
      o_hsync_invert <= 1'b0;
      o_vsync_invert <= 1'b0;
      o_full24 <= 1'b0;
      o_interlace <= 1'b0;
      o_gpio1_out <= 1'b0;
      o_gpio1_oe <= 1'b0;
    end else if (i_ce) begin
      o_stop_disable <= five_q[`GICR_F5_STOP];
      o_buffer_alloc <= five_q[10:9];
      o_vid_clk_slave_oe <= five_q[`GICR_F5_DSLV];
      o_dac_d16_oe <= five_q[`GICR_F5_D16] & ~five_q[`GICR_F5_FULL24];
      o_vclk_sel <= {five_q[`GICR_F5_VSEL], i_init_config_one_vsel};
      o_retrace_sync <= five_q[`GICR_F5_RSYNC];
      o_border_en <= five_q[19:16];
      o_scan_double <= five_q[21:20];
      o_gamma_en <= five_q[22];
      o_hsync_invert <= five_q[23];
      o_vsync_invert <= five_q[24];
      o_full24 <= five_q[`GICR_F5_FULL24];
      o_interlace <= five_q[26];
      o_gpio1_out <= five_q[`GICR_F5_GP1SEL] ? five_q[`GICR_F5_GP1] : i_gpio3_in;
      o_gpio1_oe <= ~five_q[`GICR_F5_W24];
    end
  end

  // ********************************
  // Register six controls
  // ********************************
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_active_cnt <= 3'h0;
      o_drag_cnt <= 5'h00;
      o_sli_master <= 1'b0;
      o_fifo_rdy_n <= 1'b1;
    end else if (i_ce) begin
      o_active_cnt <= swap12 ? six_q[2:0] : 3'h0;
      o_drag_cnt <= swap12 ? six_q[7:3] : 5'h00;
      o_sli_master <= (i_swap_alg == `GICR_SWAP_SLI) & six_q[`GICR_F6_MASTER];
      o_fifo_rdy_n <= ~(free8 >= {1'b0, six_q[27:21]});
    end
  end
endmodule

/* inc/gicr_defines.vh */
// Purpose: Constants for the init configuration register bank
// Assumes: Included by the core files only
// Notes: Register selects are local codes; bus addressing is outside
`ifndef GICR_DEFINES_VH
`define GICR_DEFINES_VH
`define GICR_SEL_FOUR 2'h0
`define GICR_SEL_FIVE 2'h1
`define GICR_SEL_SIX 2'h2
`define GICR_FOUR_RESET 32'h00000001
`define GICR_FOUR_MASK 32'h0FFFFFFF
`define GICR_FIVE_WMASK 32'h0FFFBE19
`define GICR_SIX_WMASK 32'h3FFFFFFF
`define GICR_F5_RO_MASK 32'h000041E6
`define GICR_F4_WS 0
`define GICR_F4_RA 1
`define GICR_F5_STOP 0
`define GICR_F5_66 1
`define GICR_F5_W24 2
`define GICR_F5_GP1 4
`define GICR_F5_DSLV 11
`define GICR_F5_D16 12
`define GICR_F5_VSEL 13
`define GICR_F5_DUAL 14
`define GICR_F5_RSYNC 15
`define GICR_F5_FULL24 25
`define GICR_F5_GP1SEL 27
`define GICR_F6_MASTER 8
`define GICR_PIN_DRV_LO 2'h2
`define GICR_PIN_DRV_HI 2'h3
`define GICR_PIN_INTERNAL 2'h0
`define GICR_PIN_TRI 2'h1
`define GICR_SWAP_SLI 2'h3
`endif

/* verification/gicr_pins.sv */
// Purpose: Board pins around the bank
// Assumes: Every shared pin has a pull-up
// Notes: Undriven pins read high
module gicr_pins (
  input wire logic o_gpio2_out, o_gpio2_oe, o_gpio3_out, o_gpio3_oe, o_sli_syncin_out, o_sli_syncin_oe,
  input wire logic o_sli_syncout_out, o_sli_syncout_oe, o_dac_rd_out, o_dac_rd_oe, o_dac_wr_out, o_dac_wr_oe,
  output wire logic i_gpio2_in, i_gpio3_in, i_sli_syncin_in, i_sli_syncout_in, i_dac_rd_in, i_dac_wr_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pin level from its driver or the pull-up
  assign i_gpio2_in = o_gpio2_oe ? o_gpio2_out : 1'h1;
  assign i_gpio3_in = o_gpio3_oe ? o_gpio3_out : 1'h1;
  assign i_sli_syncin_in = o_sli_syncin_oe ? o_sli_syncin_out : 1'h1;
  assign i_sli_syncout_in = o_sli_syncout_oe ? o_sli_syncout_out : 1'h1;
  assign i_dac_rd_in = o_dac_rd_oe ? o_dac_rd_out : 1'h1;
  assign i_dac_wr_in = o_dac_wr_oe ? o_dac_wr_out : 1'h1;
endmodule

/* verification/gicr_regs_asserts.sv */
// Purpose: Port checks of the init config register bank
// Assumes: Outputs follow their source one enabled cycle later
// Notes: Bound to gicr_regs after the module
module gicr_regs_asserts (
  input wire logic i_core_clk, i_resetn, i_ce, i_config_write_unlock, i_wr, i_init_config_one_vsel,
  input wire logic [1:0] i_sel, i_swap_alg, o_buffer_alloc, o_vclk_sel, o_scan_double,
  input wire logic [31:0] i_wdata,
  input wire logic o_read_two_ws, o_read_ahead_en, o_vid_clk_slave_oe, o_dac_d16_oe, o_retrace_sync,
  input wire logic o_gamma_en, o_hsync_invert, o_vsync_invert, o_full24, o_interlace, o_sli_master,
  input wire logic [9:0] o_mem_fifo_start_row, o_mem_fifo_rollover_row,
  input wire logic [3:0] o_border_en,
  input wire logic [2:0] o_active_cnt,
  input wire logic [4:0] o_drag_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Write detection
  // ****************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire wr_en = i_ce & i_wr & i_config_write_unlock;
  wire wr4 = wr_en & (i_sel == 2'h0);
  wire wr5 = wr_en & (i_sel == 2'h1);
  sequence s_wr4; wr4 ##1 i_ce; endsequence
  sequence s_wr5; wr5 ##1 i_ce; endsequence
  AST_WS: assert property (s_wr4 |=> o_read_two_ws == $past(i_wdata[0], 2))
    else $error("wait state select differs from written bit");
  AST_LOCK: assert property ($changed(o_read_two_ws) |-> $past(wr4, 2) || !$past(i_ce))
    else $error("wait state select changed without an unlocked write");
  AST_FOUR: assert property (s_wr4 |=> {o_mem_fifo_rollover_row, o_mem_fifo_start_row, o_read_ahead_en} ==
    $past({i_wdata[27:8], i_wdata[1]}, 2)) else $error("row window or read ahead differs from write");
  AST_FIVE: assert property (s_wr5 |=> {o_interlace, o_full24, o_vsync_invert, o_hsync_invert, o_gamma_en,
    o_scan_double, o_border_en, o_retrace_sync, o_vid_clk_slave_oe, o_buffer_alloc} ==
    $past({i_wdata[26:15], i_wdata[11:9]}, 2)) else $error("video controls differ from write");
  AST_D16: assert property (o_dac_d16_oe |-> !o_full24)
    else $error("bit sixteen driver on with full width output");
  AST_VSEL: assert property ($past(i_ce) && $past(i_resetn) |-> o_vclk_sel[0] == $past(i_init_config_one_vsel))
    else $error("clock select low bit does not follow its input");
  AST_SLI: assert property (o_sli_master && $past(i_ce) && $past(i_resetn) |-> $past(i_swap_alg) == 2'h3)
    else $error("interleave master outside swap code three");
  AST_CNT: assert property ((|o_active_cnt || |o_drag_cnt) && $past(i_ce) && $past(i_resetn) |->
    $past(i_swap_alg) inside {2'h1, 2'h2}) else $error("window counters applied outside swap codes one and two");
endmodule
bind gicr_regs gicr_regs_asserts u_chk (.*);

/* verification/tb.sv */
// Purpose: Self-checking bench of the init config bank
// Assumes: Width strap low so the shared pins are ours
// Notes: Pins pulled up by the board model
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 0, i_resetn = 0, i_ce = 1, i_config_write_unlock = 1, i_wr = 0, i_init_config_one_vsel = 1;
  logic i_sli_syncin_strap = 1, i_sli_syncout_int = 0, i_dac_rd_int = 0, i_dac_wr_int = 1;
  logic [1:0] i_sel = 0, i_swap_alg = 0;
  logic [31:0] i_wdata = 0, o_rdata;
  logic [8:0] i_frame_mem_addr_b_straps = 9'h0E9;
  logic [6:0] i_pci_fifo_free = 7'h10;
  wire i_gpio2_in, i_gpio3_in, i_sli_syncin_in, i_sli_syncout_in, i_dac_rd_in, i_dac_wr_in;
  logic o_read_two_ws, o_read_ahead_en, o_mem_fifo_spill, o_stop_disable, o_vid_clk_slave_oe, o_dac_d16_oe;
  logic o_retrace_sync, o_gamma_en, o_hsync_invert, o_vsync_invert, o_full24, o_interlace;
  logic o_gpio1_out, o_gpio1_oe, o_sli_master, o_fifo_rdy_n;
  logic [9:0] o_mem_fifo_start_row, o_mem_fifo_rollover_row;
  logic [1:0] o_buffer_alloc, o_vclk_sel, o_scan_double;
  logic [3:0] o_border_en;
  logic [2:0] o_active_cnt;
  logic [4:0] o_drag_cnt;
  wire o_gpio2_out, o_gpio2_oe, o_gpio3_out, o_gpio3_oe, o_sli_syncin_out, o_sli_syncin_oe;
  wire o_sli_syncout_out, o_sli_syncout_oe, o_dac_rd_out, o_dac_rd_oe, o_dac_wr_out, o_dac_wr_oe;
  int failures = 0;
  int compares = 0;
  gicr_regs uut (.*);
  gicr_pins pins (.*);
  always #2.5 i_core_clk = ~i_core_clk;
  // ****************
  // Shared tasks
  // ****************
  task chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [1:0] s, input logic [31:0] d, input logic u, c);
    @(posedge i_core_clk);
    i_sel <= s;
    i_wdata <= d;
    i_config_write_unlock <= u;
    i_ce <= c;
    i_wr <= 1'h1;
    @(posedge i_core_clk);
    i_wr <= 1'h0;
    i_ce <= 1'h1;
    i_config_write_unlock <= 1'h1;
  endtask
  task look;
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  task rd(input logic [1:0] s, input logic [31:0] e);
    @(posedge i_core_clk);
    i_sel <= s;
    look();
    chk("read", o_rdata, e);
  endtask
  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_reset;
    rd(1, 32'h000040E9);
    rd(0, 32'h00000001);
    rd(2, 32'h00187E00);
    chk("reset", {o_stop_disable, o_read_two_ws, o_read_ahead_en, o_gpio1_oe, o_gpio1_out, o_fifo_rdy_n,
      o_sli_syncout_oe, o_sli_syncout_out, o_dac_rd_oe, o_dac_rd_out}, 10'h36A);
    $display("reset test done");
  endtask
  task t_four;
    wr(0, 32'hFFFFFFFE, 1, 1);
    look();
    chk("four", {o_read_two_ws, o_read_ahead_en, o_mem_fifo_spill}, 3'h3);
    chk("rows", {o_mem_fifo_rollover_row, o_mem_fifo_start_row}, 20'hFFFFF);
    wr(0, 32'h00000001, 0, 1);
    wr(0, 32'h00000001, 1, 0);
    wr(3, 32'hFFFFFFFF, 1, 1);
    rd(0, 32'h0FFFFFFE);
    rd(3, 32'h00000000);
    wr(0, 32'h00000301, 1, 1);
    look();
    chk("four2", {o_read_two_ws, o_mem_fifo_spill, o_read_ahead_en, o_mem_fifo_start_row}, 13'h1003);
    $display("four test done");
  endtask
  task t_five;
    wr(1, 32'hFFFFEFFF, 1, 1);
    rd(1, 32'h0FFFEEF9);
    chk("drv", {o_full24, o_dac_d16_oe, o_vid_clk_slave_oe, o_buffer_alloc}, 5'h17);
    chk("vsel", o_vclk_sel, 2'h3);
    chk("video", {o_interlace, o_vsync_invert, o_hsync_invert, o_gamma_en, o_scan_double, o_border_en,
      o_retrace_sync}, 11'h7FF);
    chk("gp1", {o_gpio1_oe, o_gpio1_out}, 2'h3);
    wr(1, 32'h00001000, 1, 1);
    look();
    chk("d16", {o_dac_d16_oe, o_full24, o_stop_disable, o_vclk_sel}, 5'h11);
    $display("five test done");
  endtask
  task t_six;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_core_clk);
      i_swap_alg <= s[1:0];
      i_init_config_one_vsel <= 1'h0;
      wr(2, 32'h000001FF, 1, 1);
      look();
      chk("cnt", {o_active_cnt, o_drag_cnt}, (s == 1 || s == 2) ? 8'hFF : 8'h00);
      chk("master", o_sli_master, s == 3);
    end
    wr(2, 32'h081CD600, 1, 1);
    rd(2, 32'h08198600);
    chk("pins", {o_gpio2_oe, o_gpio2_out, o_gpio3_oe, o_gpio3_out, o_sli_syncin_oe, o_sli_syncin_out,
      o_sli_syncout_oe, o_dac_rd_oe, o_dac_rd_out, o_dac_wr_oe, o_dac_wr_out}, 11'h74B);
    chk("gp1", o_gpio1_out, 1'h0);
    chk("rdy", o_fifo_rdy_n, 1'h1);
    @(posedge i_core_clk);
    i_pci_fifo_free <= 7'h40;
    look();
    chk("rdy2", o_fifo_rdy_n, 1'h0);
    chk("vsel2", o_vclk_sel, 2'h0);
    $display("six test done");
  endtask
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_resetn <= 1'h1;
    t_reset();
    t_four();
    t_five();
    t_six();
    complete_run();
  end
endmodule
